// ==== hdl/isr_readout.sv ====
// Readout sequencer, pixel chain and output formatter of the image sensor
`timescale 1ns/10ps
module isr_readout
	import isr_pkg::*;
#(
	parameter int ROWS      = ROWS_DEF,
	parameter int COLS      = COLS_DEF,
	parameter int FRAME_CYC = FRAME_CYC_DEF,
	parameter int LINE_GAP  = 16
)(
	input  wire logic                mclk,
	input  wire logic                rst_n,
	input  wire logic                linkClk,
	input  wire logic                linkRst_n,
	input  wire logic                wideMode,
	input  wire logic                serialSel,
	input  wire logic [1:0]          wideFmt,
	input  wire logic                singleMode,
	input  wire logic                trigger,
	input  wire logic                embedEn,
	input  wire logic [GAIN_W-1:0]   digitalGain,
	input  wire logic [11:0]         dataOffset,
	input  wire logic [15:0]         exposureRows,
	input  wire logic [ADC_W-1:0]    adcShort,
	input  wire logic [ADC_W-1:0]    adcLong,
	output logic                     rowResetStb,
	output logic [15:0]              rowResetAddr,
	output logic                     rowReadStb,
	output logic [15:0]              rowReadAddr,
	output logic                     frameValid,
	output logic                     lineValid,
	output logic [OUT_W-1:0]         pixOut,
	output logic                     pixClk,
	output logic                     bufStall
);
	localparam int PIX_CYC  = MIN_PIX_DIV;
	localparam int LINE_CYC = COLS * PIX_CYC + LINE_GAP;

	// Frame timing state in the master clock domain
	typedef struct packed {
		isr_state_type st;
		logic [31:0]   frameCnt;
		logic [15:0]   row;
		logic [15:0]   col;
		logic [3:0]    pixDiv;
		logic [15:0]   gapCnt;
		logic [1:0]    trigSync;
		logic          trigLast;
		logic          armed;
		logic          wrValid;
		logic [OUT_W-1:0] wrData;
		logic          wrFv;
		logic          wrLv;
	} isr_core_type;

	isr_core_type cur_q, cur_d;

	// Two-entry buffer between pixel chain and link
	logic [OUT_W+1:0] buf_q [2];
	logic [1:0]       bufWp_q, bufRp_q;
	logic [1:0]       rpSync1_q, rpSync2_q;
	logic [1:0]       wpSync1_q, wpSync2_q;
	logic             bufFull, linkReady;
	logic [1:0]       wpBin, rpBin, rpSyncBin;
	logic [13:0]      cmpNarrow, cmpWide;

	// Pixel chain
	logic [WIDE_W-1:0] merged;
	logic [WIDE_W-1:0] gained;
	logic [OUT_W-1:0]  formatted;
	logic [WIDE_W+GAIN_W-1:0] prod;
	logic [ADC_W-1:0]  corr;
	logic              trigRise;

	function automatic logic [13:0] compress(input logic [WIDE_W-1:0] v, input logic c14);
		logic [4:0] msb;
		logic [13:0] r;
		msb = 5'h00;
		r = 14'h0000;
		for (int i = 0; i < WIDE_W; i++)
			if (v[i])
				msb = 5'(i);
		if (c14)
		begin
			if (msb < 5'h0B)
				r = v[13:0];
			else
				r = {msb - 5'h0A, 9'(v >> (msb - 5'h09))};
		end
		else
		begin
			if (msb < 5'h09)
				r = {2'h0, v[11:0]};
			else
				r = {2'h0, msb - 5'h08, 7'(v >> (msb - 5'h07))};
		end
		return r;
	endfunction : compress

	// Pointers cross clock domains, so they step in Gray code
	function automatic logic [1:0] grayNext(input logic [1:0] g);
		logic [1:0] b;
		b = {g[1], g[1] ^ g[0]} + 2'h1;
		return {b[1], b[1] ^ b[0]};
	endfunction : grayNext

	always_comb
	begin
		corr = (adcLong > dataOffset) ? adcLong - dataOffset : 12'h000;
		if (wideMode)
			merged = (adcLong == 12'hFFF) ? {adcShort, 8'h00} : {8'h00, corr};
		else
			merged = {8'h00, corr};
		prod = merged * digitalGain;
		gained = (|prod[WIDE_W+GAIN_W-1:WIDE_W+5]) ? 20'hFFFFF : prod[WIDE_W+4:5];
		cmpNarrow = compress(gained, 1'b0);
		cmpWide = compress(gained, 1'b1);
		if (!wideMode)
			formatted = {8'h00, gained[11:0] | {12{|gained[19:12]}}};
		else if (!serialSel || wideFmt == FMT_C12)
			formatted = {8'h00, cmpNarrow[11:0]};
		else if (wideFmt == FMT_C14)
			formatted = {6'h00, cmpWide};
		else
			formatted = gained;
	end

	assign wpBin = {bufWp_q[1], bufWp_q[1] ^ bufWp_q[0]};
	assign rpBin = {bufRp_q[1], bufRp_q[1] ^ bufRp_q[0]};
	assign rpSyncBin = {rpSync2_q[1], rpSync2_q[1] ^ rpSync2_q[0]};
	assign bufFull = (wpBin ^ rpSyncBin) == 2'h2;
	assign bufStall = bufFull;
	assign trigRise = cur_q.trigSync[1] & ~cur_q.trigLast;

	always_comb
	begin
		cur_d = cur_q;
		cur_d.trigSync = {cur_q.trigSync[0], trigger};
		cur_d.trigLast = cur_q.trigSync[1];
		cur_d.frameCnt = (cur_q.frameCnt == 32'(FRAME_CYC - 1)) ? 32'h0 : cur_q.frameCnt + 32'h1;
		if (trigRise)
			cur_d.armed = 1'b1;
		cur_d.wrValid = 1'b0;
		unique case (cur_q.st)
			ST_IDLE:
			begin
				if (cur_q.frameCnt == 32'h0 && (!singleMode || cur_q.armed))
				begin
					cur_d.st = ST_LINE;
					cur_d.row = 16'h0;
					cur_d.col = 16'h0;
					cur_d.pixDiv = 4'h0;
					cur_d.armed = trigRise;
				end
			end
			ST_LINE:
			begin
				if (!bufFull)
				begin
					cur_d.pixDiv = (cur_q.pixDiv == 4'(PIX_CYC - 1)) ? 4'h0 : cur_q.pixDiv + 4'h1;
					if (cur_q.pixDiv == 4'h0)
					begin
						cur_d.wrValid = 1'b1;
						cur_d.wrFv = 1'b1;
						cur_d.wrLv = 1'b1;
						if (embedEn && (cur_q.row < 16'(EMBED_LINES)))
							cur_d.wrData = {8'h00, EMBED_HEAD ^ cur_q.col[11:0]};
						else if (embedEn && (cur_q.row >= 16'(ROWS - EMBED_LINES)))
							cur_d.wrData = {8'h00, EMBED_TAIL ^ cur_q.col[11:0]};
						else
							cur_d.wrData = formatted;
						cur_d.col = cur_q.col + 16'h1;
						if (cur_q.col == 16'(COLS - 1))
						begin
							cur_d.st = ST_GAP;
							cur_d.gapCnt = 16'h0;
						end
					end
				end
			end
			ST_GAP:
			begin
				cur_d.gapCnt = cur_q.gapCnt + 16'h1;
				if (cur_q.gapCnt == 16'(LINE_GAP - 1))
				begin
					cur_d.col = 16'h0;
					cur_d.pixDiv = 4'h0;
					cur_d.row = cur_q.row + 16'h1;
					cur_d.st = (cur_q.row == 16'(ROWS - 1)) ? ST_WAIT : ST_LINE;
				end
			end
			ST_WAIT:
			begin
				cur_d.wrValid = !bufFull;
				cur_d.wrFv = 1'b0;
				cur_d.wrLv = 1'b0;
				if (!bufFull)
					cur_d.st = ST_IDLE;
			end
		endcase
		if (!rst_n)
		begin
			cur_d = '0;
			cur_d.st = ST_IDLE;
		end
	end

	always_ff @(posedge mclk)
		cur_q <= cur_d;

	// Row sequencing: reset row leads read row by exposure
	always_comb
	begin
		rowReadStb = cur_q.st == ST_GAP && cur_q.gapCnt == 16'h0;
		rowReadAddr = cur_q.row;
		rowResetAddr = (cur_q.row + exposureRows) % 16'(ROWS);
		rowResetStb = rowReadStb;
	end

	// Buffer write side, master clock
	always_ff @(posedge mclk)
	begin
		if (!rst_n)
			bufWp_q <= 2'h0;
		else if (cur_q.wrValid && !bufFull)
			bufWp_q <= grayNext(bufWp_q);
		if (cur_q.wrValid && !bufFull)
			buf_q[wpBin[0]] <= {cur_q.wrFv, cur_q.wrLv, cur_q.wrData};
		rpSync1_q <= rst_n ? bufRp_q : 2'h0;
		rpSync2_q <= rst_n ? rpSync1_q : 2'h0;
	end

	// Link side: drains the buffer one word per link clock
	assign linkReady = bufRp_q != wpSync2_q;
	assign pixClk = linkClk;

	always_ff @(posedge linkClk)
	begin
		wpSync1_q <= linkRst_n ? bufWp_q : 2'h0;
		wpSync2_q <= linkRst_n ? wpSync1_q : 2'h0;
		if (!linkRst_n)
		begin
			bufRp_q <= 2'h0;
			frameValid <= 1'b0;
			lineValid <= 1'b0;
			pixOut <= '0;
		end
		else if (linkReady)
		begin
			bufRp_q <= grayNext(bufRp_q);
			frameValid <= buf_q[rpBin[0]][OUT_W+1];
			lineValid <= buf_q[rpBin[0]][OUT_W];
			pixOut <= buf_q[rpBin[0]][OUT_W-1:0];
		end
		else
			lineValid <= 1'b0;
	end

	chk_line_in_frame: assert property (@(posedge linkClk) disable iff (!linkRst_n)
		lineValid |-> frameValid)
		else $error("line qualifier outside frame");
	chk_pix_spacing: assert property (@(posedge mclk) disable iff (!rst_n)
		cur_q.wrValid && cur_q.wrLv |=> !(cur_q.wrValid && cur_q.wrLv))
		else $error("pixels closer than rate limit");
	chk_linear_width: assert property (@(posedge mclk) disable iff (!rst_n)
		cur_q.wrValid && !wideMode && $stable(wideMode) |-> cur_q.wrData[19:12] == 8'h00)
		else $error("linear pixel wider than 12 bits");
	chk_row_order: assert property (@(posedge mclk) disable iff (!rst_n)
		cur_q.st == ST_GAP && cur_d.st == ST_LINE |=> cur_q.row == $past(cur_q.row) + 16'h1)
		else $error("rows out of order");
	chk_frame_start: assert property (@(posedge mclk) disable iff (!rst_n)
		cur_q.st == ST_IDLE && cur_d.st == ST_LINE |-> cur_q.frameCnt == 32'h0)
		else $error("frame start off period");
	chk_single_hold: assert property (@(posedge mclk) disable iff (!rst_n)
		cur_q.st == ST_IDLE && singleMode && !cur_q.armed |=> cur_q.st == ST_IDLE)
		else $error("single frame started without trigger");
	chk_read_reset: assert property (@(posedge mclk) disable iff (!rst_n)
		rowReadStb |-> rowResetStb && rowResetAddr == (rowReadAddr + exposureRows) % 16'(ROWS))
		else $error("exposure interval wrong");
	chk_buf_bound: assert property (@(posedge mclk) disable iff (!rst_n)
		bufFull |=> bufWp_q == $past(bufWp_q))
		else $error("write into full buffer");

	// Crossing pointers move one bit at a time
	chk_wr_gray_step: assert property (@(posedge mclk) disable iff (!rst_n)
		bufWp_q != $past(bufWp_q) |-> $countones(bufWp_q ^ $past(bufWp_q)) == 1)
		else $error("write pointer skipped a code");
	chk_rd_gray_step: assert property (@(posedge linkClk) disable iff (!linkRst_n)
		bufRp_q != $past(bufRp_q) |-> $countones(bufRp_q ^ $past(bufRp_q)) == 1)
		else $error("read pointer skipped a code");

	// Output formats
	chk_parallel_c12: assert property (@(posedge mclk) disable iff (!rst_n)
		wideMode && !serialSel |-> formatted[19:12] == 8'h00)
		else $error("parallel wide pixel wider than 12 bits");
	chk_serial_c14: assert property (@(posedge mclk) disable iff (!rst_n)
		wideMode && serialSel && wideFmt == FMT_C14 |-> formatted[19:14] == 6'h00)
		else $error("compressed pixel wider than 14 bits");
	chk_linear_pass: assert property (@(posedge mclk) disable iff (!rst_n)
		!wideMode && digitalGain == 8'(GAIN_ONE) && dataOffset == 12'h000
		|-> formatted == {8'h00, adcLong})
		else $error("unity linear pixel altered");
	chk_merge_wide: assert property (@(posedge mclk) disable iff (!rst_n)
		wideMode && serialSel && wideFmt == FMT_L20 && adcLong == 12'hFFF
		&& digitalGain == 8'(GAIN_ONE) |-> formatted == {adcShort, 8'h00})
		else $error("saturated capture not merged");
	chk_gain_sat: assert property (@(posedge mclk) disable iff (!rst_n)
		|prod[WIDE_W+GAIN_W-1:WIDE_W+5] |-> gained == 20'hFFFFF)
		else $error("gain overflow not clipped");

	// Sequencing
	chk_strobe_once: assert property (@(posedge mclk) disable iff (!rst_n)
		rowReadStb |=> !rowReadStb)
		else $error("row read strobe longer than one cycle");
	chk_trig_arm: assert property (@(posedge mclk) disable iff (!rst_n)
		trigRise |=> cur_q.armed)
		else $error("trigger edge not armed");
	chk_end_word: assert property (@(posedge mclk) disable iff (!rst_n)
		cur_q.st == ST_WAIT && !bufFull |=> cur_q.wrValid && !cur_q.wrFv && !cur_q.wrLv)
		else $error("frame end word missing");
	chk_frame_close: assert property (@(posedge linkClk) disable iff (!linkRst_n)
		$fell(frameValid) |-> !lineValid)
		else $error("line qualifier at frame end");
endmodule : isr_readout

// ==== hdl/isr_pkg.sv ====
// Constants and types for the image sensor readout and output block
// What this block does
// - Default: 960-line frames at 22.5 fps, one per two 45 fps frame periods
// - Linear mode sends offset-corrected, gained 12-bit pixels
// - Wide-range parallel output is 12-bit compressed
// - Wide-range serial: 12, 14 or 20 bits
// - Free-running video or triggered single frame
// - Frame, line qualifiers; parallel pixel clock
// - Embed fixed head and tail marker patterns XOR column index in first, last two lines
// - Progressive rows at constant frame rate
// - Sequencing on the master clock; pixel clock is the separate link clock
// - Output pixel rate at most 74.25 MHz
// - Rows reset then read in order
// - Exposure equals reset-to-read row interval
// - Converter yields 12 bits per pixel
// - Corrections and digital gain before output
// - Wide-range mode merges captures into 20 bits
// - Compress 20-bit pixels to 12 or 14
package isr_pkg;
	localparam int ROWS_DEF       = 960;
	localparam int COLS_DEF       = 1280;
	localparam int FPS_DEF        = 45;
	localparam int MCLK_HZ        = 100_000_000;
	localparam int FRAME_CYC_DEF  = MCLK_HZ / FPS_DEF;
	localparam int MAX_PIX_KHZ    = 74_250;
	localparam int MIN_PIX_DIV    = (MCLK_HZ / 1000 + MAX_PIX_KHZ - 1) / MAX_PIX_KHZ;
	localparam int EMBED_LINES    = 2;
	localparam int ADC_W          = 12;
	localparam int WIDE_W         = 20;
	localparam int OUT_W          = 20;
	localparam int GAIN_W         = 8;
	localparam int GAIN_ONE       = 8'h20;
	localparam logic [11:0] EMBED_HEAD = 12'hA5A;
	localparam logic [11:0] EMBED_TAIL = 12'h5A5;
	typedef enum logic [1:0] {FMT_C12 = 2'h0, FMT_C14 = 2'h1, FMT_L20 = 2'h2} isr_fmt_type;
	typedef enum logic [1:0] {ST_IDLE = 2'h0, ST_LINE = 2'h1, ST_GAP = 2'h3, ST_WAIT = 2'h2}
		isr_state_type;
endpackage : isr_pkg

// ==== sim/isr_host_rx.sv ====
// Host receiver model that gathers each output frame
`timescale 1ns/10ps
module isr_host_rx
	import isr_pkg::*;
(
	input  wire logic             pixClk,
	input  wire logic             frameValid,
	input  wire logic             lineValid,
	input  wire logic [OUT_W-1:0] pixOut,
	output int                    frames,
	output int                    pixels,
	output logic [OUT_W-1:0]      orAll,
	output logic [OUT_W-1:0]      firstPix,
	output logic                  badLine
);
	logic fvPrev = 1'b0;
	initial frames = 0;
	always @(posedge pixClk)
	begin
		if (frameValid && !fvPrev)
		begin
			pixels = 0;
			orAll = '0;
			badLine = 1'b0;
		end
		if (lineValid)
		begin
			if (pixels == 0)
				firstPix = pixOut;
			pixels++;
			orAll = orAll | pixOut;
		end
		if (lineValid && !frameValid)
			badLine = 1'b1;
		if (fvPrev && !frameValid)
			frames++;
		fvPrev = frameValid;
	end
endmodule : isr_host_rx

// ==== sim/tb_image_sensor_readout_output.sv ====
// Self-checking bench for the sensor readout and output block
`timescale 1ns/10ps
module tb_image_sensor_readout_output
	import isr_pkg::*;
;
	localparam int R = 4;
	localparam int C = 8;
	localparam int FC = 4000;
	logic              mclk = 1'b0, linkClk = 1'b0, rst_n = 1'b0, linkRst_n = 1'b0;
	logic              wideMode = 1'b0, serialSel = 1'b0, singleMode = 1'b0;
	logic              trigger = 1'b0, embedEn = 1'b0, stallSeen = 1'b0;
	logic [1:0]        wideFmt = 2'h0;
	logic [GAIN_W-1:0] digitalGain = 8'h20;
	logic [11:0]       dataOffset = 12'h000, v = 12'h000;
	logic [15:0]       exposureRows = 16'h0002, rowResetAddr, rowReadAddr;
	logic [ADC_W-1:0]  adcShort = 12'h000, adcLong = 12'h000;
	logic              rowResetStb, rowReadStb, frameValid, lineValid, pixClk, bufStall, badLine;
	logic [OUT_W-1:0]  pixOut, orAll, firstPix;
	int                frames, pixels, fails = 0, n_checks = 0, cyc = 0;
	int                lastRd = -1, lastRs = -1, row0Cyc = -1;
	always #5 mclk = ~mclk;
	always #80 linkClk = ~linkClk;
	isr_readout #(.ROWS(R), .COLS(C), .FRAME_CYC(FC), .LINE_GAP(16)) dut (
		.mclk, .rst_n, .linkClk, .linkRst_n, .wideMode, .serialSel, .wideFmt, .singleMode,
		.trigger, .embedEn, .digitalGain, .dataOffset, .exposureRows, .adcShort, .adcLong,
		.rowResetStb, .rowResetAddr, .rowReadStb, .rowReadAddr, .frameValid, .lineValid,
		.pixOut, .pixClk, .bufStall);
	isr_host_rx rx (.pixClk, .frameValid, .lineValid, .pixOut, .frames, .pixels, .orAll,
		.firstPix, .badLine);
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp)
		begin
			fails++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check
	task automatic stop_test;
		$display("checks=%0d fails=%0d", n_checks, fails);
		if (fails == 0 && n_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : stop_test
	task automatic waitFrame;
		int f;
		f = frames;
		for (int i = 0; i < 20000 && frames == f; i++)
			@(posedge mclk);
	endtask : waitFrame
	task automatic checkFrame(input int w, input bit chk, input logic [OUT_W-1:0] first);
		check(pixels, R * C);
		check(badLine, 1'b0);
		check(orAll >> w, 0);
		if (chk)
			check(firstPix, first);
	endtask : checkFrame
	task automatic newPixel(input int lim);
		@(posedge mclk);
		v = 12'($urandom_range(lim, 1));
		adcShort <= v;
		adcLong <= v;
	endtask : newPixel
	always @(posedge mclk)
	begin
		cyc++;
		if (bufStall === 1'b1)
			stallSeen <= 1'b1;
		if (rst_n && rowReadStb === 1'b1)
		begin
			if (lastRd >= 0)
				check(rowReadAddr, (lastRd + 1) % R);
			if (rowReadAddr == 0 && row0Cyc >= 0 && !singleMode)
				check(cyc - row0Cyc, FC);
			if (rowReadAddr == 0)
				row0Cyc = cyc;
			lastRd = rowReadAddr;
		end
		if (rst_n && rowResetStb === 1'b1)
		begin
			if (lastRs >= 0)
				check(rowResetAddr, (lastRs + 1) % R);
			lastRs = rowResetAddr;
		end
		if (cyc == 90000)
		begin
			fails++;
			stop_test();
		end
	end
	initial
	begin
		int f;
		void'($urandom(28));
		newPixel(4095);
		repeat (11) @(posedge mclk);
		repeat (3) @(posedge linkClk);
		linkRst_n <= 1'b1;
		@(posedge mclk);
		rst_n <= 1'b1;
		waitFrame();
		checkFrame(12, 1, {8'h00, v});
		check(stallSeen, 1'b1);
		check(bufStall, 1'b0);
		for (int m = 0; m < 5; m++)
		begin
			newPixel(4095);
			wideMode <= (m > 0);
			serialSel <= (m != 1);
			wideFmt <= (m < 3) ? 2'h0 : 2'(m - 2);
			waitFrame();
			checkFrame((m == 3) ? 14 : (m == 4) ? 20 : 12, m == 0, {8'h00, v});
		end
		newPixel(2047);
		wideMode <= 1'b0;
		serialSel <= 1'b0;
		digitalGain <= 8'h40;
		waitFrame();
		checkFrame(12, 1, {7'h00, v, 1'b0});
		@(posedge mclk);
		digitalGain <= 8'h20;
		embedEn <= 1'b1;
		waitFrame();
		checkFrame(12, 1, {8'h00, EMBED_HEAD});
		@(posedge mclk);
		embedEn <= 1'b0;
		singleMode <= 1'b1;
		repeat (2 * FC) @(posedge mclk);
		f = frames;
		repeat (2 * FC) @(posedge mclk);
		check(frames, f);
		trigger <= 1'b1;
		repeat (4) @(posedge mclk);
		trigger <= 1'b0;
		waitFrame();
		checkFrame(12, 1, {8'h00, v});
		repeat (2 * FC) @(posedge mclk);
		check(frames, f + 1);
		stop_test();
	end
endmodule : tb_image_sensor_readout_output
